//--- rcam_top.v
// Remote configuration and alarm monitor with AXI4-Lite registers
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "rcam_consts.vh"
module rcam_top #(
  parameter MS_CYCLES = `RCAM_MS_CYCLES
) (
  input wire clk,
  input wire arst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire overvoltage_alarm,
  input wire overcurrent_alarm,
  input wire overpower_alarm,
  input wire constant_voltage_regulation,
  input wire remote_standby_input,
  input wire power_fail_alarm,
  input wire overtemperature_alarm,
  input wire panel_on,
  input wire panel_off,
  input wire link_connected,
  input wire serial_byte,
  input wire msg_valid,
  input wire msg_register_protocol,
  output reg msg_accept,
  output reg msg_discard,
  output reg watchdog_action,
  output reg terminal_on,
  output reg alarm_pin_out,
  output reg status_pin_out,
  output wire analog_ref_10v,
  output wire [15:0] resistance_set,
  output wire irq
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [6:0] pins;
  rcam_sync #(.WIDTH(7)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in({overvoltage_alarm, overcurrent_alarm, overpower_alarm,
      constant_voltage_regulation, remote_standby_input,
      power_fail_alarm, overtemperature_alarm}),
    .sync_out(pins)
  );
  wire ov = pins[6];
  wire oc = pins[5];
  wire op = pins[4];
  wire vr = pins[3];
  wire sb_pin = pins[2];
  wire mf = pins[1];
  wire th = pins[0];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [`RCAM_CFG_WIDTH-1:0] cfg;
  reg [15:0] ser_tmo;
  reg [15:0] wdg_tmo;
  reg wdg_en;
  reg [15:0] res_set;
  reg [`RCAM_IRQ_WIDTH-1:0] irq_stat;
  reg [`RCAM_IRQ_WIDTH-1:0] irq_mask;
  reg wto_flag;
  reg ever_on;

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  wire wr_do = aw_held && w_held && !s_axi_bvalid;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  wire [31:0] cfg_new = merge({20'h00000, cfg}, w_data, w_strb);
  wire [31:0] ser_new = merge({16'h0000, ser_tmo}, w_data, w_strb);
  wire [31:0] wdg_new = merge({16'h0000, wdg_tmo}, w_data, w_strb);
  wire [31:0] res_new = merge({16'h0000, res_set}, w_data, w_strb);
  wire [31:0] ctl_new = merge({31'h00000000, wdg_en}, w_data, w_strb);
  wire [31:0] msk_new = merge({28'h0000000, irq_mask}, w_data, w_strb);
  wire [31:0] w1c = merge(32'h00000000, w_data, w_strb);

  wire wr_cfg = wr_do && aw_addr == `RCAM_REG_CONFIG;
  wire wr_ser = wr_do && aw_addr == `RCAM_REG_SER_TMO;
  wire wr_wdg = wr_do && aw_addr == `RCAM_REG_WDG_TMO;
  wire wr_ctl = wr_do && aw_addr == `RCAM_REG_WDG_CTRL;
  wire wr_res = wr_do && aw_addr == `RCAM_REG_RES_SET;
  wire wr_ost = wr_do && aw_addr == `RCAM_REG_OPER_STAT;
  wire wr_ist = wr_do && aw_addr == `RCAM_REG_IRQ_STAT;
  wire wr_msk = wr_do && aw_addr == `RCAM_REG_IRQ_MASK;
  wire wr_cmd = wr_do && aw_addr == `RCAM_REG_TERM_CMD;
  wire wr_hit = wr_cfg | wr_ser | wr_wdg | wr_ctl | wr_res | wr_ost |
    wr_ist | wr_msk | wr_cmd;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Configuration storage
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= `RCAM_CFG_RESET;
      ser_tmo <= `RCAM_SER_TMO_RESET;
      wdg_tmo <= `RCAM_WDG_TMO_RESET;
      wdg_en <= 1'b0;
      res_set <= 16'h0000;
      irq_mask <= {`RCAM_IRQ_WIDTH{1'b0}};
    end else begin
      if (wr_cfg) begin
        // [R8] refuse both disables
        if (cfg_new[`RCAM_CFG_REGP_DIS] && cfg_new[`RCAM_CFG_TXTP_DIS]) begin
          cfg <= {cfg_new[`RCAM_CFG_WIDTH-1:`RCAM_CFG_TXTP_DIS+1],
            cfg[`RCAM_CFG_TXTP_DIS:`RCAM_CFG_REGP_DIS],
            cfg_new[`RCAM_CFG_REGP_DIS-1:0]};
        end else begin
          cfg <= cfg_new[`RCAM_CFG_WIDTH-1:0];
        end
      end
      // [R9] gap timeout range
      if (wr_ser && ser_new[15:0] >= `RCAM_SER_TMO_MIN) begin
        ser_tmo <= ser_new[15:0];
      end
      // [R10] watchdog seconds range
      if (wr_wdg && wdg_new[15:0] >= `RCAM_WDG_TMO_MIN &&
          wdg_new[15:0] <= `RCAM_WDG_TMO_MAX) begin
        wdg_tmo <= wdg_new[15:0];
      end
      if (wr_ctl) begin
        wdg_en <= ctl_new[0];
      end
      // [R6] resistance only in U/I/R
      if (wr_res && cfg[`RCAM_CFG_RES_MODE]) begin
        res_set <= res_new[15:0];
      end
      if (wr_msk) begin
        irq_mask <= msk_new[`RCAM_IRQ_WIDTH-1:0];
      end
    end
  end

  // [R16] reference range select
  assign analog_ref_10v = !cfg[`RCAM_CFG_REF_5V];
  assign resistance_set = res_set;

  // ----------------------------------------
  // Message gating and serial gap timer
  // ----------------------------------------
  reg [15:0] gap_cyc;
  reg [15:0] gap_ms;
  reg msg_open;
  wire gap_ms_tick = msg_open && gap_cyc == MS_CYCLES - 1;
  wire gap_expire = gap_ms_tick && gap_ms + 16'h0001 >= ser_tmo;
  wire good_msg = msg_valid && !(msg_register_protocol ?
    cfg[`RCAM_CFG_REGP_DIS] : cfg[`RCAM_CFG_TXTP_DIS]);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_cyc <= 16'h0000;
      gap_ms <= 16'h0000;
      msg_open <= 1'b0;
      msg_accept <= 1'b0;
      msg_discard <= 1'b0;
    end else begin
      // [R7] drop disabled protocol
      msg_accept <= good_msg;
      msg_discard <= gap_expire && !serial_byte && !msg_valid;
      if (msg_valid) begin
        msg_open <= 1'b0;
      end else if (serial_byte) begin
        msg_open <= 1'b1;
        gap_cyc <= 16'h0000;
        gap_ms <= 16'h0000;
      end else if (gap_expire) begin
        // [R9] discard partial message
        msg_open <= 1'b0;
      end else if (gap_ms_tick) begin
        gap_cyc <= 16'h0000;
        gap_ms <= gap_ms + 16'h0001;
      end else if (msg_open) begin
        gap_cyc <= gap_cyc + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Connection watchdog
  // ----------------------------------------
  reg [15:0] wd_cyc;
  reg [9:0] wd_ms;
  reg [15:0] wd_sec;
  reg wd_run;
  reg link_d;
  wire link_rise = link_connected && !link_d;
  wire wd_ms_tick = wd_run && wd_cyc == MS_CYCLES - 1;
  wire wd_s_tick = wd_ms_tick && wd_ms == `RCAM_MS_PER_S - 1;
  wire wd_expire = wd_s_tick && wd_sec + 16'h0001 >= wdg_tmo;
  wire wd_restart = link_rise || (link_connected && good_msg);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_cyc <= 16'h0000;
      wd_ms <= 10'h000;
      wd_sec <= 16'h0000;
      wd_run <= 1'b0;
      link_d <= 1'b0;
      watchdog_action <= 1'b0;
    end else begin
      link_d <= link_connected;
      watchdog_action <= wd_expire;
      // [R13] idle unless enabled
      if (!wdg_en || !link_connected) begin
        wd_run <= 1'b0;
      end else if (wd_restart) begin
        // [R11] [R18] start or restart timing
        wd_run <= 1'b1;
        wd_cyc <= 16'h0000;
        wd_ms <= 10'h000;
        wd_sec <= 16'h0000;
      end else if (wd_expire) begin
        wd_run <= 1'b0;
      end else if (wd_s_tick) begin
        wd_cyc <= 16'h0000;
        wd_ms <= 10'h000;
        wd_sec <= wd_sec + 16'h0001;
      end else if (wd_ms_tick) begin
        wd_cyc <= 16'h0000;
        wd_ms <= wd_ms + 10'h001;
      end else if (wd_run) begin
        wd_cyc <= wd_cyc + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // DC terminal control
  // ----------------------------------------
  reg sb_d;
  reg mf_d;
  reg th_d;
  reg mf_saved;
  reg th_saved;
  reg sb_switched_off;
  // [R3] standby polarity
  wire sb_act = sb_pin ^ cfg[`RCAM_CFG_SB_INV];
  wire sb_rise = sb_act && !sb_d;
  wire sb_fall = !sb_act && sb_d;
  wire mf_rise = mf && !mf_d;
  wire mf_fall = !mf && mf_d;
  wire th_rise = th && !th_d;
  wire th_fall = !th && th_d;
  wire cmd_on = panel_on || (wr_cmd && w1c[0]);
  wire cmd_off = panel_off || (wr_cmd && w1c[1]) || wd_expire;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sb_d <= 1'b0;
      mf_d <= 1'b0;
      th_d <= 1'b0;
      mf_saved <= 1'b0;
      th_saved <= 1'b0;
      sb_switched_off <= 1'b0;
      terminal_on <= 1'b0;
      ever_on <= 1'b0;
    end else begin
      sb_d <= sb_act;
      mf_d <= mf;
      th_d <= th;
      if (mf_rise || th_rise) begin
        terminal_on <= 1'b0;
        if (mf_rise) begin
          mf_saved <= terminal_on;
        end
        if (th_rise) begin
          th_saved <= terminal_on;
        end
      end else if (mf || th) begin
        terminal_on <= 1'b0;
      end else if (mf_fall) begin
        // [R14] power fail restore policy
        terminal_on <= cfg[`RCAM_CFG_MF_AUTO] && mf_saved;
      end else if (th_fall) begin
        // [R15] overtemperature restore policy
        terminal_on <= !cfg[`RCAM_CFG_TH_OFF] && th_saved;
      end else if (cmd_off) begin
        terminal_on <= 1'b0;
        sb_switched_off <= 1'b0;
      end else if (cmd_on) begin
        terminal_on <= 1'b1;
        ever_on <= 1'b1;
        sb_switched_off <= 1'b0;
      end else if (sb_rise) begin
        // [R4] standby switches off
        sb_switched_off <= terminal_on;
        terminal_on <= 1'b0;
      end else if (sb_fall) begin
        // [R5] auto on only after once on
        if (cfg[`RCAM_CFG_SB_AUTO] && ever_on && sb_switched_off) begin
          terminal_on <= 1'b1;
        end
        sb_switched_off <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Analog interface output pins
  // ----------------------------------------
  reg next_alarm;
  always @* begin
    // [R1] alarm source mux
    case (cfg[`RCAM_CFG_ALSEL_MSB:`RCAM_CFG_ALSEL_LSB])
      `RCAM_AL_OV: next_alarm = ov;
      `RCAM_AL_OC: next_alarm = oc;
      `RCAM_AL_OP: next_alarm = op;
      `RCAM_AL_OV_OC: next_alarm = ov | oc;
      `RCAM_AL_OV_OP: next_alarm = ov | op;
      `RCAM_AL_OC_OP: next_alarm = oc | op;
      default: next_alarm = ov | oc | op;
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_pin_out <= 1'b0;
      status_pin_out <= 1'b0;
    end else begin
      // [R17] registered pin outputs
      alarm_pin_out <= next_alarm;
      // [R2] status pin source
      status_pin_out <= cfg[`RCAM_CFG_STSEL] ? terminal_on : vr;
    end
  end

  // ----------------------------------------
  // Status flags and interrupt
  // ----------------------------------------
  wire [`RCAM_IRQ_WIDTH-1:0] irq_set = {th_rise, mf_rise,
    msg_discard, wd_expire};

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wto_flag <= 1'b0;
      irq_stat <= {`RCAM_IRQ_WIDTH{1'b0}};
    end else begin
      // [R12] timeout flag, set wins
      if (wd_expire) begin
        wto_flag <= 1'b1;
      end else if (wr_ost && w1c[`RCAM_ST_WTO]) begin
        wto_flag <= 1'b0;
      end
      irq_stat <= irq_set |
        (irq_stat & ~(wr_ist ? w1c[`RCAM_IRQ_WIDTH-1:0] :
        {`RCAM_IRQ_WIDTH{1'b0}}));
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  reg [31:0] rd_word;
  reg rd_hit;
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    rd_hit = 1'b1;
    case (ra)
      `RCAM_REG_CONFIG: rd_word = {20'h00000, cfg};
      `RCAM_REG_SER_TMO: rd_word = {16'h0000, ser_tmo};
      `RCAM_REG_WDG_TMO: rd_word = {16'h0000, wdg_tmo};
      `RCAM_REG_WDG_CTRL: rd_word = {31'h00000000, wdg_en};
      `RCAM_REG_RES_SET: rd_word = {16'h0000, res_set};
      `RCAM_REG_OPER_STAT: rd_word = {26'h0000000, status_pin_out,
        alarm_pin_out, sb_act, wto_flag, ever_on, terminal_on};
      `RCAM_REG_IRQ_STAT: rd_word = {28'h0000000, irq_stat};
      `RCAM_REG_IRQ_MASK: rd_word = {28'h0000000, irq_mask};
      `RCAM_REG_TERM_CMD: rd_word = 32'h00000000;
      default: begin
        rd_word = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- rcam_consts.vh
// Constants for the remote configuration and alarm monitor
// Notes on behaviour
// [R1] Alarm pin shows OV, OC, OP, any pair, or all three ORed.
// [R2] Status pin shows constant-voltage regulation (default) or terminal state.
// [R3] Standby input read with normal polarity by default, or inverted.
// [R4] Standby action off-only: standby input may only switch terminal off.
// [R5] Standby action auto: off and on again, after terminal was once on.
// [R6] Select power or resistance mode; resistance value accepted only in resistance mode.
// [R7] Register protocol disabled: its messages ignored, only text accepted, kept.
// [R8] Both command protocols may never be disabled at the same time.
// [R9] Serial message discarded when byte gap exceeds ms timeout, default 5.
// [R10] Connection watchdog timeout in seconds, default five seconds.
// [R11] Enabled watchdog starts timing when a connection is established.
// [R12] Watchdog expiry triggers the action and sets connection-timeout flag.
// [R13] Watchdog disabled after device reset until enabled again.
// [R14] After power fail clears: restore prior state (auto) or stay off (default).
// [R15] After overtemperature: restore prior state (default) or stay off.
// [R16] Reference range select, default 10 V, no effect on digital control.
// [R17] Alarm and status pin outputs registered for glitch-free changes.
// [R18] Every valid received message restarts the watchdog count.
`ifndef RCAM_CONSTS_VH
`define RCAM_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RCAM_REG_CONFIG 8'h00
`define RCAM_REG_SER_TMO 8'h04
`define RCAM_REG_WDG_TMO 8'h08
`define RCAM_REG_WDG_CTRL 8'h0C
`define RCAM_REG_RES_SET 8'h10
`define RCAM_REG_OPER_STAT 8'h14
`define RCAM_REG_IRQ_STAT 8'h18
`define RCAM_REG_IRQ_MASK 8'h1C
`define RCAM_REG_TERM_CMD 8'h20

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define RCAM_CFG_ALSEL_LSB 0
`define RCAM_CFG_ALSEL_MSB 2
`define RCAM_CFG_STSEL 3
`define RCAM_CFG_SB_INV 4
`define RCAM_CFG_SB_AUTO 5
`define RCAM_CFG_RES_MODE 6
`define RCAM_CFG_REGP_DIS 7
`define RCAM_CFG_TXTP_DIS 8
`define RCAM_CFG_MF_AUTO 9
`define RCAM_CFG_TH_OFF 10
`define RCAM_CFG_REF_5V 11
`define RCAM_CFG_WIDTH 12
`define RCAM_CFG_RESET 12'h006

// Alarm pin source codes
`define RCAM_AL_OV 3'h0
`define RCAM_AL_OC 3'h1
`define RCAM_AL_OP 3'h2
`define RCAM_AL_OV_OC 3'h3
`define RCAM_AL_OV_OP 3'h4
`define RCAM_AL_OC_OP 3'h5
`define RCAM_AL_ALL 3'h6

// ----------------------------------------
// Timeouts and timing
// ----------------------------------------
`define RCAM_SER_TMO_MIN 16'h0005
`define RCAM_SER_TMO_RESET 16'h0005
`define RCAM_WDG_TMO_MIN 16'h0001
`define RCAM_WDG_TMO_MAX 16'h8CA0
`define RCAM_WDG_TMO_RESET 16'h0005
`define RCAM_CLK_HZ 50000000
`define RCAM_MS_PER_S 1000
`define RCAM_MS_CYCLES (`RCAM_CLK_HZ / 1000)

// Status and interrupt bits
`define RCAM_ST_TERM_ON 0
`define RCAM_ST_EVER_ON 1
`define RCAM_ST_WTO 2
`define RCAM_ST_STANDBY 3
`define RCAM_ST_ALARM_PIN 4
`define RCAM_ST_STATUS_PIN 5
`define RCAM_IRQ_WTO 0
`define RCAM_IRQ_DISCARD 1
`define RCAM_IRQ_MF 2
`define RCAM_IRQ_TH 3
`define RCAM_IRQ_WIDTH 4

`endif

//--- rcam_sync.v
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rcam_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire arst_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

//--- rcam_asserts.sv
// Port-level assertions of the alarm monitor
`timescale 1ns/1ps
module rcam_asserts #(
  parameter MS_CYCLES = 10
) (
  input wire clk,
  input wire arst_n,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire msg_valid,
  input wire msg_accept,
  input wire serial_byte,
  input wire msg_discard,
  input wire watchdog_action,
  input wire terminal_on,
  input wire link_connected,
  input wire analog_ref_10v
);
  localparam int GAP_MIN = 5 * MS_CYCLES - 1;
  localparam int WDG_MIN = 1000 * MS_CYCLES - 3;
  int gap;
  int quiet;
  // Cycles since last byte, and since last host activity
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap <= 0;
      quiet <= 0;
    end else begin
      gap <= serial_byte ? 0 : gap + 1;
      quiet <= (msg_accept || !link_connected) ? 0 : quiet + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_accept_cause: assert property (
    msg_accept |-> $past(msg_valid)) else $error("accept without message");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_discard_gap: assert property (
    msg_discard |-> gap >= GAP_MIN) else $error("discard too early");
  a_discard_pulse: assert property (
    msg_discard |=> !msg_discard) else $error("discard not a pulse");
  a_wdg_quiet: assert property (
    watchdog_action |-> quiet >= WDG_MIN) else $error("watchdog too early");
  a_wdg_off: assert property (
    watchdog_action |-> !terminal_on) else $error("terminal left on");
  a_wdg_link: assert property (
    watchdog_action |-> $past(link_connected)) else $error("no link");
  a_ref_default: assert property (
    $rose(arst_n) |-> analog_ref_10v) else $error("range not 10 V");
  c_discard: cover property (msg_discard);
  c_wdg: cover property (watchdog_action);
  c_rwait: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

//--- rcam_host.sv
// Host model: link state and message strobes
`timescale 1ns/1ps
module rcam_host (
  input wire clk,
  output reg serial_byte,
  output reg msg_valid,
  output reg msg_register_protocol,
  output reg link_connected
);
  initial begin
    serial_byte = 1'h0;
    msg_valid = 1'h0;
    msg_register_protocol = 1'h0;
    link_connected = 1'h0;
  end
  // Three bytes, then optionally the closing strobe
  task send(input proto, input close);
    integer i;
    begin
      for (i = 0; i < 3; i++) begin
        @(posedge clk);
        serial_byte <= 1'h1;
        @(posedge clk);
        serial_byte <= 1'h0;
      end
      if (close) begin
        msg_register_protocol <= proto;
        msg_valid <= 1'h1;
        @(posedge clk);
        msg_valid <= 1'h0;
        msg_register_protocol <= ~proto;
      end
    end
  endtask
  task link(input up);
    begin
      @(posedge clk);
      link_connected <= up;
    end
  endtask
endmodule

//--- rcam_top_bench.sv
// Self-checking bench of the alarm monitor
`timescale 1ns/1ps
`include "rcam_consts.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module rcam_top_bench;
  localparam MS_CYCLES = 10;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] rsp;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, overvoltage_alarm, overcurrent_alarm;
  logic overpower_alarm, constant_voltage_regulation, panel_on, panel_off;
  logic remote_standby_input, power_fail_alarm, overtemperature_alarm;
  logic wdg_seen = 1'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire s_axi_rvalid, serial_byte, msg_valid, msg_register_protocol;
  wire link_connected, msg_accept, msg_discard, watchdog_action;
  wire terminal_on, alarm_pin_out, status_pin_out, analog_ref_10v, irq;
  wire [15:0] resistance_set;
  int failures = 0, checks = 0, cyc = 0, acc = 0, n, i;
  logic [7:0] rows [15] = '{8'h03, 8'h0C, 8'h15, 8'h1A, 8'h29, 8'h26,
    8'h35, 8'h38, 8'h49, 8'h44, 8'h52, 8'h55, 8'h63, 8'h60, 8'h79};

  rcam_top #(.MS_CYCLES(MS_CYCLES)) dut (.*);
  rcam_host host (.clk, .serial_byte, .msg_valid, .msg_register_protocol,
    .link_connected);

  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (msg_accept === 1'h1) acc++;
    if (watchdog_action === 1'h1) wdg_seen = 1'h1;
    if (cyc == 40000) begin
      failures++;
      print_verdict;
    end
  end

  task print_verdict;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // ----
  // Bus master, panel button and pin tasks
  // ----
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      while (!(s_axi_bready && s_axi_bvalid)) begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
        if (s_axi_bvalid) s_axi_bready <= 1'h1;
      end
      rsp = s_axi_bresp;
      s_axi_bready <= 1'h0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      while (!(s_axi_rready && s_axi_rvalid)) begin
        @(posedge clk);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
        if (s_axi_rvalid) s_axi_rready <= 1'h1;
      end
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'h0;
    end
  endtask
  task press(input on);
    begin
      @(posedge clk);
      if (on) panel_on <= 1'h1;
      else panel_off <= 1'h1;
      @(posedge clk);
      panel_on <= 1'h0;
      panel_off <= 1'h0;
      repeat (2) @(posedge clk);
    end
  endtask
  // Standby, power fail, overtemperature pins, then sync time
  task pin3(input [2:0] v);
    begin
      {remote_standby_input, power_fail_alarm, overtemperature_alarm} <= v;
      repeat (5) @(posedge clk);
    end
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid,
     s_axi_bready, s_axi_arvalid, s_axi_rready, overvoltage_alarm,
     overcurrent_alarm, overpower_alarm, panel_on, panel_off,
     remote_standby_input, power_fail_alarm, overtemperature_alarm} = '0;
    constant_voltage_regulation = 1'h1;
    repeat (6) @(posedge clk);
    arst_n <= 1'h1;
    rd(`RCAM_REG_CONFIG);
    `CHK(rdat, 32'h00000006)
    `CHK(analog_ref_10v, 1'h1)
    `CHK(status_pin_out, 1'h1)
    rd(`RCAM_REG_SER_TMO);
    `CHK(rdat, 32'h00000005)
    rd(`RCAM_REG_WDG_TMO);
    `CHK(rdat, 32'h00000005)
    rd(`RCAM_REG_WDG_CTRL);
    `CHK(rdat, 32'h00000000)
    rd(8'h40);
    `CHK(rsp, 2'h2)
    wr(8'h40, 32'h00000001);
    `CHK(rsp, 2'h2)
    for (i = 0; i < 15; i++) begin
      wr(`RCAM_REG_CONFIG, {29'h0, rows[i][6:4]});
      {overpower_alarm, overcurrent_alarm, overvoltage_alarm} <= rows[i][3:1];
      repeat (5) @(posedge clk);
      `CHK(alarm_pin_out, rows[i][0])
    end
    wr(`RCAM_REG_CONFIG, 32'h00000006);
    press(1'h1);
    pin3(3'h4);
    `CHK(terminal_on, 1'h0)
    pin3(3'h0);
    `CHK(terminal_on, 1'h0)
    wr(`RCAM_REG_CONFIG, 32'h00000026);
    press(1'h1);
    pin3(3'h4);
    pin3(3'h0);
    `CHK(terminal_on, 1'h1)
    wr(`RCAM_REG_CONFIG, 32'h00000036);
    repeat (5) @(posedge clk);
    `CHK(terminal_on, 1'h0)
    pin3(3'h4);
    `CHK(terminal_on, 1'h1)
    pin3(3'h0);
    wr(`RCAM_REG_CONFIG, 32'h0000000E);
    wr(`RCAM_REG_TERM_CMD, 32'h1);
    `CHK(status_pin_out, 1'h1)
    press(1'h0);
    `CHK(status_pin_out, 1'h0)
    wr(`RCAM_REG_CONFIG, 32'h00000006);
    press(1'h1);
    pin3(3'h2);
    pin3(3'h0);
    `CHK(terminal_on, 1'h0)
    wr(`RCAM_REG_CONFIG, 32'h00000206);
    press(1'h1);
    pin3(3'h2);
    `CHK(terminal_on, 1'h0)
    pin3(3'h0);
    `CHK(terminal_on, 1'h1)
    pin3(3'h1);
    pin3(3'h0);
    `CHK(terminal_on, 1'h1)
    wr(`RCAM_REG_CONFIG, 32'h00000406);
    pin3(3'h1);
    pin3(3'h0);
    `CHK(terminal_on, 1'h0)
    wr(`RCAM_REG_CONFIG, 32'h00000806);
    `CHK(analog_ref_10v, 1'h0)
    wr(`RCAM_REG_RES_SET, 32'h00001234);
    `CHK(resistance_set, 16'h0000)
    wr(`RCAM_REG_CONFIG, 32'h00000046);
    wr(`RCAM_REG_RES_SET, 32'h00001234);
    `CHK(resistance_set, 16'h1234)
    wr(`RCAM_REG_CONFIG, 32'h00000186);
    rd(`RCAM_REG_CONFIG);
    `CHK(rdat, 32'h00000006)
    wr(`RCAM_REG_CONFIG, 32'h00000086);
    n = acc;
    host.send(1'h1, 1'h1);
    repeat (2) @(posedge clk);
    `CHK(acc - n, 0)
    host.send(1'h0, 1'h1);
    repeat (2) @(posedge clk);
    `CHK(acc - n, 1)
    wr(`RCAM_REG_CONFIG, 32'h106);
    host.send(1'h0, 1'h1);
    host.send(1'h1, 1'h1);
    repeat (2) @(posedge clk);
    `CHK(acc - n, 2)
    wr(`RCAM_REG_SER_TMO, 32'h00000004);
    rd(`RCAM_REG_SER_TMO);
    `CHK(rdat, 32'h00000005)
    host.send(1'h0, 1'h0);
    n = 0;
    while (msg_discard !== 1'h1) begin
      @(posedge clk);
      n++;
    end
    `CHK(n >= 45 && n <= 55, 1'h1)
    repeat (2) @(posedge clk);
    `CHK(irq, 1'h0)
    wr(`RCAM_REG_IRQ_MASK, 32'h00000002);
    `CHK(irq, 1'h1)
    wr(`RCAM_REG_IRQ_STAT, 32'h00000002);
    `CHK(irq, 1'h0)
    wr(`RCAM_REG_WDG_TMO, 32'h00000001);
    wr(`RCAM_REG_WDG_CTRL, 32'h00000001);
    press(1'h1);
    host.link(1'h1);
    repeat (6000) @(posedge clk);
    host.send(1'h1, 1'h1);
    repeat (6000) @(posedge clk);
    `CHK(wdg_seen, 1'h0)
    while (wdg_seen !== 1'h1) @(posedge clk);
    `CHK(terminal_on, 1'h0)
    rd(`RCAM_REG_OPER_STAT);
    `CHK(rdat[2], 1'h1)
    wr(`RCAM_REG_IRQ_MASK, 32'h00000001);
    `CHK(irq, 1'h1)
    wr(`RCAM_REG_IRQ_STAT, 32'h00000001);
    `CHK(irq, 1'h0)
    host.link(1'h0);
    print_verdict;
  end
endmodule

bind rcam_top rcam_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk, .arst_n,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .msg_valid, .msg_accept, .serial_byte,
  .msg_discard, .watchdog_action, .terminal_on, .link_connected,
  .analog_ref_10v);
